/* File: design/feu_fault_escalation_unit.sv */
`timescale 1ns/10ps
`default_nettype none

module feu_fault_escalation_unit #(
    parameter int PRIO_W = feu_pkg::FEU_PRIO_W,
    parameter int ADDR_W = feu_pkg::FEU_ADDR_W
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_vector_read_err,
    input wire logic i_fetch_mpu_violation,
    input wire logic i_fetch_no_execute_region,
    input wire logic i_data_mpu_violation,
    input wire logic i_push_mpu_violation,
    input wire logic i_pop_mpu_violation,
    input wire logic [ADDR_W-1:0] i_mem_fault_addr,
    input wire logic i_push_bus_err,
    input wire logic i_pop_bus_err,
    input wire logic i_prefetch_bus_err,
    input wire logic i_data_bus_err_exact,
    input wire logic i_data_bus_err_inexact,
    input wire logic [ADDR_W-1:0] i_bus_fault_addr,
    input wire logic i_coproc_access,
    input wire logic i_unknown_opcode,
    input wire logic i_bad_state,
    input wire logic i_bad_return_token,
    input wire logic i_misaligned_access,
    input wire logic i_zero_divisor,
    input wire logic [PRIO_W-1:0] i_mem_prio,
    input wire logic [PRIO_W-1:0] i_bus_prio,
    input wire logic [PRIO_W-1:0] i_usage_prio,
    input wire logic i_prio_we,
    input wire logic [2:0] i_handler_enable,
    input wire logic i_handler_enable_we,
    input wire logic [2:0] i_running_ctx,
    input wire logic [PRIO_W-1:0] i_running_prio,
    input wire logic i_entering_bus_handler,
    input wire logic i_nmi,
    input wire logic [1:0] i_hard_clr,
    input wire logic [4:0] i_mem_clr,
    input wire logic [5:0] i_bus_clr,
    input wire logic [5:0] i_usage_clr,
    output logic [1:0] o_hard_fault_cause_reg,
    output logic [4:0] o_mem_manage_cause_reg,
    output logic [5:0] o_bus_fault_cause_reg,
    output logic [5:0] o_usage_fault_cause_reg,
    output logic [ADDR_W-1:0] o_mem_manage_addr_reg,
    output logic [ADDR_W-1:0] o_bus_error_addr_reg,
    output logic [3*PRIO_W-1:0] o_fault_priority_reg,
    output logic [2:0] o_handler_enable_reg,
    output logic o_fault_req,
    output logic [2:0] o_fault_class,
    output logic o_lockup
);
    logic [1:0] hard_q;
    logic [4:0] mem_q;
    logic [5:0] bus_q;
    logic [5:0] usage_q;
    logic [ADDR_W-1:0] mem_addr_q;
    logic [ADDR_W-1:0] bus_addr_q;
    logic [3*PRIO_W-1:0] prio_q;
    logic [2:0] enable_q;
    logic req_q;
    feu_pkg::feu_class_type class_q;
    feu_pkg::feu_lock_type lock_q;
    feu_pkg::feu_class_type class_d;
    logic mem_hit;
    logic bus_hit;
    logic bus_hit_esc;
    logic usage_hit;
    logic mem_esc;
    logic bus_esc;
    logic usage_esc;
    logic escalate;
    logic hard_hit;
    logic in_fault_ctx;
    logic fixed_ctx;
    logic [PRIO_W-1:0] mem_p;
    logic [PRIO_W-1:0] bus_p;
    logic [PRIO_W-1:0] usage_p;

    // Class detection from the raw error lines
    assign mem_hit = i_fetch_mpu_violation | i_fetch_no_execute_region
        | i_data_mpu_violation | i_push_mpu_violation
        | i_pop_mpu_violation;
    assign bus_hit = i_push_bus_err | i_pop_bus_err | i_prefetch_bus_err
        | i_data_bus_err_exact | i_data_bus_err_inexact;
    // A broken push into the bus handler keeps the bus class
    assign bus_hit_esc = bus_hit
        & ~(i_push_bus_err & i_entering_bus_handler);
    assign usage_hit = i_coproc_access | i_unknown_opcode | i_bad_state
        | i_bad_return_token | i_misaligned_access | i_zero_divisor;
    assign in_fault_ctx = (i_running_ctx != feu_pkg::FEU_CTX_THREAD);
    // Hard fault and NMI handlers sit above every configurable class
    assign fixed_ctx = (i_running_ctx == feu_pkg::FEU_CTX_HARD)
        | (i_running_ctx == feu_pkg::FEU_CTX_NMI);

    assign mem_p = prio_q[PRIO_W-1:0];
    assign bus_p = prio_q[2*PRIO_W-1:PRIO_W];
    assign usage_p = prio_q[3*PRIO_W-1:2*PRIO_W];

    // Lower number is more urgent and equal priority never preempts, so
    // a fault that cannot preempt the running handler escalates instead
    always_comb begin
        mem_esc = 1'b0;
        bus_esc = 1'b0;
        usage_esc = 1'b0;
        if (mem_hit) begin
            mem_esc = ~enable_q[0];
            if (fixed_ctx) begin
                mem_esc = 1'b1;
            end else if (in_fault_ctx && mem_p >= i_running_prio) begin
                mem_esc = 1'b1;
            end
        end
        if (bus_hit_esc) begin
            bus_esc = ~enable_q[1];
            if (fixed_ctx) begin
                bus_esc = 1'b1;
            end else if (in_fault_ctx && bus_p >= i_running_prio) begin
                bus_esc = 1'b1;
            end
        end
        if (usage_hit) begin
            usage_esc = ~enable_q[2];
            if (fixed_ctx) begin
                usage_esc = 1'b1;
            end else if (in_fault_ctx && usage_p >= i_running_prio) begin
                usage_esc = 1'b1;
            end
        end
    end
    assign escalate = mem_esc | bus_esc | usage_esc;
    assign hard_hit = escalate | i_vector_read_err;

    // Hard fault outranks every configurable class
    always_comb begin
        if (hard_hit) begin
            class_d = feu_pkg::FEU_CLS_HARD;
        end else if (mem_hit) begin
            class_d = feu_pkg::FEU_CLS_MEM;
        end else if (bus_hit) begin
            class_d = feu_pkg::FEU_CLS_BUS;
        end else if (usage_hit) begin
            class_d = feu_pkg::FEU_CLS_USAGE;
        end else begin
            class_d = feu_pkg::FEU_CLS_NONE;
        end
    end

    // Handler request, suppressed while locked up
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            req_q <= 1'b0;
        end else begin
            req_q <= (class_d != feu_pkg::FEU_CLS_NONE)
                && (lock_q == feu_pkg::FEU_LK_RUN);
        end
    end

    // Class of the previous cycle's fault, NONE if there was none; only meaningful beside the request
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            class_q <= feu_pkg::FEU_CLS_NONE;
        end else begin
            class_q <= class_d;
        end
    end

    // Priority and enable settings from software
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prio_q <= feu_pkg::FEU_PRIO_RESET;
            enable_q <= feu_pkg::FEU_EN_RESET;
        end else begin
            if (i_prio_we) begin
                prio_q <= {i_usage_prio, i_bus_prio, i_mem_prio};
            end
            if (i_handler_enable_we) begin
                enable_q <= i_handler_enable;
            end
        end
    end

    // Hard fault causes; set beats clear
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hard_q <= feu_pkg::FEU_HF_RESET;
        end else begin
            hard_q <= hard_q & ~i_hard_clr;
            if (i_vector_read_err) begin
                hard_q[feu_pkg::FEU_HF_VECTOR_READ_ERROR_FLAG] <= 1'b1;
            end
            if (escalate) begin
                hard_q[feu_pkg::FEU_HF_ESC] <= 1'b1;
            end
        end
    end

    // Address of the latest data violation, held until overwritten
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mem_addr_q <= feu_pkg::FEU_ADDR_RESET;
        end else if (i_data_mpu_violation) begin
            mem_addr_q <= i_mem_fault_addr;
        end
    end

    // Memory management causes
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mem_q <= feu_pkg::FEU_MM_RESET;
        end else begin
            mem_q <= mem_q & ~i_mem_clr;
            if (i_fetch_mpu_violation | i_fetch_no_execute_region) begin
                mem_q[feu_pkg::FEU_MM_FETCH] <= 1'b1;
            end
            if (i_data_mpu_violation) begin
                mem_q[feu_pkg::FEU_MM_DATA] <= 1'b1;
                mem_q[feu_pkg::FEU_MM_ADDR_VALID] <= 1'b1;
            end
            if (i_push_mpu_violation) begin
                mem_q[feu_pkg::FEU_MM_PUSH] <= 1'b1;
            end
            if (i_pop_mpu_violation) begin
                mem_q[feu_pkg::FEU_MM_POP] <= 1'b1;
            end
        end
    end

    // Only exact errors carry a usable address
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_addr_q <= feu_pkg::FEU_ADDR_RESET;
        end else if (i_data_bus_err_exact) begin
            bus_addr_q <= i_bus_fault_addr;
        end
    end

    // Bus fault causes
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_q <= feu_pkg::FEU_BF_RESET;
        end else begin
            bus_q <= bus_q & ~i_bus_clr;
            if (i_prefetch_bus_err) begin
                bus_q[feu_pkg::FEU_BF_PREFETCH] <= 1'b1;
            end
            if (i_data_bus_err_exact) begin
                bus_q[feu_pkg::FEU_BF_EXACT] <= 1'b1;
                bus_q[feu_pkg::FEU_BF_ADDR_VALID] <= 1'b1;
            end
            if (i_data_bus_err_inexact) begin
                bus_q[feu_pkg::FEU_BF_INEXACT] <= 1'b1;
            end
            if (i_push_bus_err) begin
                bus_q[feu_pkg::FEU_BF_PUSH] <= 1'b1;
            end
            if (i_pop_bus_err) begin
                bus_q[feu_pkg::FEU_BF_POP] <= 1'b1;
            end
        end
    end

    // Usage fault causes
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            usage_q <= feu_pkg::FEU_UF_RESET;
        end else begin
            usage_q <= usage_q & ~i_usage_clr;
            if (i_coproc_access) begin
                usage_q[feu_pkg::FEU_UF_COPROC] <= 1'b1;
            end
            if (i_unknown_opcode) begin
                usage_q[feu_pkg::FEU_UF_OPCODE] <= 1'b1;
            end
            if (i_bad_state) begin
                usage_q[feu_pkg::FEU_UF_STATE] <= 1'b1;
            end
            if (i_bad_return_token) begin
                usage_q[feu_pkg::FEU_UF_RETURN] <= 1'b1;
            end
            if (i_misaligned_access) begin
                usage_q[feu_pkg::FEU_UF_ALIGN] <= 1'b1;
            end
            if (i_zero_divisor) begin
                usage_q[feu_pkg::FEU_UF_ZERO_DIVISOR_FLAG] <= 1'b1;
            end
        end
    end

    // Lockup; the NMI origin is remembered so NMI cannot free it
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            lock_q <= feu_pkg::FEU_LK_RUN;
        end else begin
            case (lock_q)
                feu_pkg::FEU_LK_RUN: begin
                    if (hard_hit && i_running_ctx == feu_pkg::FEU_CTX_NMI) begin
                        lock_q <= feu_pkg::FEU_LK_NMI;
                    end else if (hard_hit
                            && i_running_ctx == feu_pkg::FEU_CTX_HARD) begin
                        lock_q <= feu_pkg::FEU_LK_HARD;
                    end
                end
                feu_pkg::FEU_LK_HARD: begin
                    if (i_nmi) begin
                        lock_q <= feu_pkg::FEU_LK_RUN;
                    end
                end
                default: begin
                    lock_q <= feu_pkg::FEU_LK_NMI;
                end
            endcase
        end
    end

    assign o_hard_fault_cause_reg = hard_q;
    assign o_mem_manage_cause_reg = mem_q;
    assign o_bus_fault_cause_reg = bus_q;
    assign o_usage_fault_cause_reg = usage_q;
    assign o_mem_manage_addr_reg = mem_addr_q;
    assign o_bus_error_addr_reg = bus_addr_q;
    assign o_fault_priority_reg = prio_q;
    assign o_handler_enable_reg = enable_q;
    assign o_fault_req = req_q;
    assign o_fault_class = class_q;
    assign o_lockup = (lock_q != feu_pkg::FEU_LK_RUN);
endmodule

`default_nettype wire

/* File: design/feu_pkg.sv */
package feu_pkg;
    // Fault classes, doubling as handler selection codes
    typedef enum logic [2:0] {
        FEU_CLS_NONE = 3'h0,
        FEU_CLS_MEM = 3'h1,
        FEU_CLS_BUS = 3'h2,
        FEU_CLS_USAGE = 3'h3,
        FEU_CLS_HARD = 3'h4
    } feu_class_type;

    // Running context of the core
    typedef enum logic [2:0] {
        FEU_CTX_THREAD = 3'h0,
        FEU_CTX_HANDLER = 3'h1,
        FEU_CTX_HARD = 3'h3,
        FEU_CTX_NMI = 3'h2
    } feu_ctx_type;

    // Lockup state machine, Gray along run <-> hard; run -> nmi flips both bits
    typedef enum logic [1:0] {
        FEU_LK_RUN = 2'h0,
        FEU_LK_HARD = 2'h1,
        FEU_LK_NMI = 2'h3
    } feu_lock_type;

    localparam int FEU_PRIO_W = 3;
    localparam int FEU_ADDR_W = 32;

    // Hard fault cause bits
    localparam int FEU_HF_VECTOR_READ_ERROR_FLAG = 0;
    localparam int FEU_HF_ESC = 1;
    // Memory management cause bits
    localparam int FEU_MM_FETCH = 0;
    localparam int FEU_MM_DATA = 1;
    localparam int FEU_MM_POP = 2;
    localparam int FEU_MM_PUSH = 3;
    localparam int FEU_MM_ADDR_VALID = 4;
    // Bus fault cause bits
    localparam int FEU_BF_PREFETCH = 0;
    localparam int FEU_BF_EXACT = 1;
    localparam int FEU_BF_INEXACT = 2;
    localparam int FEU_BF_POP = 3;
    localparam int FEU_BF_PUSH = 4;
    localparam int FEU_BF_ADDR_VALID = 5;
    // Usage fault cause bits
    localparam int FEU_UF_OPCODE = 0;
    localparam int FEU_UF_STATE = 1;
    localparam int FEU_UF_RETURN = 2;
    localparam int FEU_UF_COPROC = 3;
    localparam int FEU_UF_ALIGN = 4;
    localparam int FEU_UF_ZERO_DIVISOR_FLAG = 5;

    localparam logic [1:0] FEU_HF_RESET = 2'h0;
    localparam logic [4:0] FEU_MM_RESET = 5'h00;
    localparam logic [5:0] FEU_BF_RESET = 6'h00;
    localparam logic [5:0] FEU_UF_RESET = 6'h00;
    localparam logic [31:0] FEU_ADDR_RESET = 32'h0000_0000;
    localparam logic [8:0] FEU_PRIO_RESET = 9'h000;
    localparam logic [2:0] FEU_EN_RESET = 3'h0;
endpackage

/* File: testbench/feu_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Core side: turns a cause number into a one-cycle event pulse
module feu_core_model (
    input wire logic i_core_clk,
    input wire logic i_fire,
    input wire logic [4:0] i_sel,
    output logic [17:0] o_pulse
);
    // Falling-edge launch keeps the unit's sampling edge race free
    initial o_pulse = 18'h00000;
    always @(negedge i_core_clk) begin
        o_pulse <= i_fire ? 18'h00001 << i_sel : 18'h00000;
    end
endmodule
`default_nettype wire

/* File: testbench/feu_fault_escalation_unit_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// Flags, escalation and lockup seen from the unit's ports
module feu_checker #(
    parameter int PRIO_W = 3,
    parameter int ADDR_W = 32
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_vector_read_err,
    input wire logic i_fetch_mpu_violation,
    input wire logic i_fetch_no_execute_region,
    input wire logic i_data_mpu_violation,
    input wire logic [ADDR_W-1:0] i_mem_fault_addr,
    input wire logic i_data_bus_err_exact,
    input wire logic [ADDR_W-1:0] i_bus_fault_addr,
    input wire logic i_bad_state,
    input wire logic i_prio_we,
    input wire logic i_handler_enable_we,
    input wire logic [2:0] i_running_ctx,
    input wire logic [PRIO_W-1:0] i_running_prio,
    input wire logic i_nmi,
    input wire logic [5:0] i_usage_clr,
    input wire logic [1:0] o_hard_fault_cause_reg,
    input wire logic [4:0] o_mem_manage_cause_reg,
    input wire logic [5:0] o_bus_fault_cause_reg,
    input wire logic [5:0] o_usage_fault_cause_reg,
    input wire logic [ADDR_W-1:0] o_mem_manage_addr_reg,
    input wire logic [ADDR_W-1:0] o_bus_error_addr_reg,
    input wire logic [3*PRIO_W-1:0] o_fault_priority_reg,
    input wire logic [2:0] o_handler_enable_reg,
    input wire logic o_fault_req,
    input wire logic [2:0] o_fault_class,
    input wire logic o_lockup
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    vector_read_error_flag_flag_a: assert property (i_vector_read_err
        |=> o_hard_fault_cause_reg[0]) else $error("vector flag missing");
    fetch_flag_a: assert property (
        i_fetch_mpu_violation || i_fetch_no_execute_region
        |=> o_mem_manage_cause_reg[0]) else $error("fetch flag missing");
    data_capture_a: assert property (i_data_mpu_violation
        |=> o_mem_manage_cause_reg[1]
        && o_mem_manage_addr_reg == $past(i_mem_fault_addr))
        else $error("data violation not captured");
    exact_capture_a: assert property (i_data_bus_err_exact
        |=> o_bus_fault_cause_reg[1]
        && o_bus_error_addr_reg == $past(i_bus_fault_addr))
        else $error("exact bus error not captured");
    // Enable write in the same cycle only takes effect a cycle later
    disabled_esc_a: assert property (i_bad_state &&
        !o_handler_enable_reg[2] && !i_handler_enable_we && !o_lockup
        |=> o_hard_fault_cause_reg[1] && o_fault_class == 3'h4)
        else $error("disabled class not escalated");
    prio_esc_a: assert property (i_bad_state &&
        i_running_ctx == 3'h1 && !i_prio_we && !o_lockup &&
        o_fault_priority_reg[3*PRIO_W-1:2*PRIO_W] >= i_running_prio
        |=> o_fault_class == 3'h4) else $error("priority not escalated");
    lock_entry_a: assert property (i_vector_read_err &&
        i_running_ctx == 3'h3 && !i_nmi |=> o_lockup)
        else $error("no lockup from hard handler");
    lock_exit_a: assert property ($fell(o_lockup)
        |-> $past(i_nmi)) else $error("lockup left without nmi");
    nmi_lock_a: assert property (o_lockup && i_nmi &&
        i_running_ctx == 3'h2 |=> o_lockup) else $error("nmi freed lockup");
    locked_req_a: assert property (o_lockup
        |=> !o_fault_req) else $error("request raised in lockup");
    sticky_flag_a: assert property ($fell(o_usage_fault_cause_reg[1])
        |-> $past(i_usage_clr[1])) else $error("flag dropped uncleared");

    cover property (o_fault_req && o_fault_class == 3'h4);
    cover property ($rose(o_lockup));
    cover property ($fell(o_lockup));
endmodule

bind feu_fault_escalation_unit feu_checker #(
    .PRIO_W(PRIO_W), .ADDR_W(ADDR_W)
) u_checker (.*);
`default_nettype wire

/* File: testbench/feu_fault_escalation_unit_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module feu_fault_escalation_unit_bench;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic fire = 1'b0;
    logic [4:0] sel = 5'h00;
    logic [17:0] p;
    logic [31:0] i_mem_fault_addr = 32'h2000_0040;
    logic [31:0] i_bus_fault_addr = 32'h4000_0008;
    logic [2:0] i_mem_prio = 3'h0, i_bus_prio = 3'h0, i_usage_prio = 3'h0;
    logic i_prio_we = 1'b0, i_handler_enable_we = 1'b0;
    logic [2:0] i_handler_enable = 3'h0, i_running_ctx = 3'h0;
    logic [2:0] i_running_prio = 3'h0;
    logic i_entering_bus_handler = 1'b0;
    logic [18:0] clr = 19'h00000;
    logic [1:0] o_hard_fault_cause_reg;
    logic [4:0] o_mem_manage_cause_reg;
    logic [5:0] o_bus_fault_cause_reg, o_usage_fault_cause_reg;
    logic [31:0] o_mem_manage_addr_reg, o_bus_error_addr_reg;
    logic [8:0] o_fault_priority_reg;
    logic [2:0] o_handler_enable_reg, o_fault_class;
    logic o_fault_req, o_lockup;
    int error_cnt = 0, n_checks = 0;
    // Position of each cause in the joined flag vector
    int flag_bit[17] = '{0, 2, 2, 3, 5, 4, 11, 10, 7, 8, 9, 16, 13, 14, 15,
        17, 18};
    wire logic [18:0] flags = {o_usage_fault_cause_reg,
        o_bus_fault_cause_reg, o_mem_manage_cause_reg, o_hard_fault_cause_reg};

    always #4 i_core_clk = ~i_core_clk;

    feu_core_model u_core (.i_core_clk, .i_fire(fire), .i_sel(sel),
        .o_pulse(p));
    feu_fault_escalation_unit DUT (.i_core_clk, .i_rst,
        .i_vector_read_err(p[0]), .i_fetch_mpu_violation(p[1]),
        .i_fetch_no_execute_region(p[2]), .i_data_mpu_violation(p[3]),
        .i_push_mpu_violation(p[4]), .i_pop_mpu_violation(p[5]),
        .i_mem_fault_addr, .i_push_bus_err(p[6]), .i_pop_bus_err(p[7]),
        .i_prefetch_bus_err(p[8]), .i_data_bus_err_exact(p[9]),
        .i_data_bus_err_inexact(p[10]), .i_bus_fault_addr,
        .i_coproc_access(p[11]), .i_unknown_opcode(p[12]),
        .i_bad_state(p[13]), .i_bad_return_token(p[14]),
        .i_misaligned_access(p[15]), .i_zero_divisor(p[16]),
        .i_mem_prio, .i_bus_prio, .i_usage_prio, .i_prio_we,
        .i_handler_enable, .i_handler_enable_we, .i_running_ctx,
        .i_running_prio, .i_entering_bus_handler, .i_nmi(p[17]),
        .i_hard_clr(clr[1:0]), .i_mem_clr(clr[6:2]),
        .i_bus_clr(clr[12:7]), .i_usage_clr(clr[18:13]),
        .o_hard_fault_cause_reg, .o_mem_manage_cause_reg,
        .o_bus_fault_cause_reg, .o_usage_fault_cause_reg,
        .o_mem_manage_addr_reg, .o_bus_error_addr_reg,
        .o_fault_priority_reg, .o_handler_enable_reg,
        .o_fault_req, .o_fault_class, .o_lockup);

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Returns in the cycle where the one-cycle answer stands
    task automatic fire_one(input int k, input logic [2:0] cls);
        @(negedge i_core_clk);
        fire <= 1'b1;
        sel <= 5'(k);
        @(negedge i_core_clk);
        fire <= 1'b0;
        @(negedge i_core_clk);
        chk("fault_class", cls, o_fault_class);
    endtask

    task automatic clear_all();
        @(negedge i_core_clk);
        clr <= 19'h7ffff;
        @(negedge i_core_clk);
        clr <= 19'h00000;
        @(negedge i_core_clk);
        chk("flags cleared", 32'h0, 32'(flags));
    endtask

    task automatic setup(input logic [2:0] en, input logic [8:0] pr,
        input logic [2:0] ctx, input logic [2:0] rp);
        @(negedge i_core_clk);
        i_handler_enable <= en;
        {i_usage_prio, i_bus_prio, i_mem_prio} <= pr;
        i_handler_enable_we <= 1'b1;
        i_prio_we <= 1'b1;
        i_running_ctx <= ctx;
        i_running_prio <= rp;
        @(negedge i_core_clk);
        i_handler_enable_we <= 1'b0;
        i_prio_we <= 1'b0;
        chk("handler_enable_reg", en, o_handler_enable_reg);
        chk("fault_priority_reg", pr, o_fault_priority_reg);
    endtask

    task automatic test_causes();
        setup(3'h7, 9'h000, 3'h0, 3'h0);
        for (int k = 0; k < 17; k++) begin
            fire_one(k, k == 0 ? 3'h4 : k < 6 ? 3'h1 : k < 11 ? 3'h2 : 3'h3);
            chk("fault_req", 1'b1, o_fault_req);
            @(negedge i_core_clk);
            chk("fault_req low", 1'b0, o_fault_req);
            chk("cause flag", 1'b1, flags[flag_bit[k]]);
            chk("mem addr valid", k == 3, flags[6]);
            chk("bus addr valid", k == 9, flags[12]);
            chk("escalation flag", 1'b0, o_hard_fault_cause_reg[1]);
            clear_all();
        end
        chk("mem_manage_addr_reg", 32'h2000_0040, o_mem_manage_addr_reg);
        chk("bus_error_addr_reg", 32'h4000_0008, o_bus_error_addr_reg);
    endtask

    task automatic test_escalation();
        // Memory and usage handlers off, bus handler on
        setup(3'h2, 9'h000, 3'h0, 3'h0);
        fire_one(3, 3'h4);
        fire_one(13, 3'h4);
        chk("escalation flag", 1'b1, o_hard_fault_cause_reg[1]);
        clear_all();
        // Usage prio 3, bus 5, mem 2 against a running prio of 3
        setup(3'h7, 9'h0ea, 3'h1, 3'h3);
        fire_one(13, 3'h4);
        fire_one(9, 3'h4);
        fire_one(1, 3'h1);
        clear_all();
        // Push bus error on the way into the bus handler stays a bus fault
        setup(3'h7, 9'h0ea, 3'h1, 3'h0);
        i_entering_bus_handler <= 1'b1;
        fire_one(6, 3'h2);
        chk("escalation flag", 1'b0, o_hard_fault_cause_reg[1]);
        i_entering_bus_handler <= 1'b0;
        fire_one(6, 3'h4);
        clear_all();
    endtask

    task automatic test_lockup();
        setup(3'h7, 9'h000, 3'h3, 3'h0);
        fire_one(0, 3'h4);
        chk("lockup", 1'b1, o_lockup);
        // Class still follows the escalated fault while the request is suppressed
        fire_one(12, 3'h4);
        chk("fault_req locked", 1'b0, o_fault_req);
        fire_one(17, 3'h0);
        chk("lockup", 1'b0, o_lockup);
        i_running_ctx <= 3'h2;
        fire_one(0, 3'h4);
        fire_one(17, 3'h0);
        chk("lockup", 1'b1, o_lockup);
        i_rst <= 1'b1;
        @(negedge i_core_clk);
        i_rst <= 1'b0;
        chk("lockup", 1'b0, o_lockup);
        chk("flags", 32'h0, 32'(flags));
    endtask

    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge i_core_clk);
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (12) @(negedge i_core_clk);
        i_rst <= 1'b0;
        @(negedge i_core_clk);
        chk("reset flags", 32'h0, 32'(flags));
        chk("reset prio", 32'h0, 32'(o_fault_priority_reg));
        chk("reset lockup", 1'b0, o_lockup);
        test_causes();
        test_escalation();
        test_lockup();
        final_report();
    end
endmodule
`default_nettype wire
